/* hdl/asop_pkg.sv */
// Package for the sample output port: widths, codes, latency and carrier types
package asop_pkg;
    localparam int ASOP_CODE_W = 12;
    localparam int ASOP_LATENCY = 6;
    localparam int ASOP_CLK_HZ = 25000000;
    localparam int ASOP_MIN_RATE_MSPS = 40;
    localparam logic [11:0] ASOP_CODE_ZERO = 12'h000;
    localparam logic [11:0] ASOP_CODE_MID = 12'h800;
    localparam logic [11:0] ASOP_CODE_FULL = 12'hfff;
    localparam logic [11:0] ASOP_SIGN_FLIP = 12'h800;
    localparam int ASOP_FS_REF_MULT = 2;

    typedef enum logic [0:0] {
        ASOP_ACTIVE = 1'b0,
        ASOP_POWER_DOWN = 1'b1
    } asop_mode_t;

    typedef struct packed {
        logic [11:0] data;
        logic [11:0] oe;
    } asop_pins_t;
endpackage

/* hdl/asop_port.sv */
// Digital side of the pipelined 12-bit converter: sampling, coding, output pins
`timescale 1ns/1ps
module asop_port
    import asop_pkg::*;
#(
    parameter int LATENCY = ASOP_LATENCY
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Quantiser result in two's complement, already scaled to 2*Vref full scale
    input wire logic signed [11:0] quant_in,
    input wire logic output_enable_n_in,
    input wire logic power_down_req_in,
    output logic [11:0] sample_code_bus_out,
    output logic [11:0] sample_code_bus_oe_out,
    output logic mode_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic oe_n_meta_reg;
    logic oe_n_sync_reg;
    logic power_down_meta_reg;
    logic power_down_sync_reg;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            oe_n_meta_reg <= 1'b1;
            oe_n_sync_reg <= 1'b1;
            power_down_meta_reg <= 1'b0;
            power_down_sync_reg <= 1'b0;
        end else begin
            oe_n_meta_reg <= output_enable_n_in;
            oe_n_sync_reg <= oe_n_meta_reg;
            power_down_meta_reg <= power_down_req_in;
            power_down_sync_reg <= power_down_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode
    asop_mode_t mode_reg;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            mode_reg <= ASOP_ACTIVE;
        end else begin
            mode_reg <= power_down_sync_reg ? ASOP_POWER_DOWN : ASOP_ACTIVE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample pipeline
    logic [11:0] code_next;
    logic [11:0] pipe_reg [LATENCY];
    logic [LATENCY-1:0] vld_reg;

    // Flipping the sign bit maps -2048..2047 onto 000..fff
    assign code_next = 12'(quant_in) ^ ASOP_SIGN_FLIP;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            vld_reg <= '0;
            for (int i = 0; i < LATENCY; i++) begin
                pipe_reg[i] <= ASOP_CODE_ZERO;
            end
        end else if (mode_reg == ASOP_ACTIVE) begin
            // One word per rising edge, no gaps
            pipe_reg[0] <= code_next;
            vld_reg[0] <= 1'b1;
            for (int i = 1; i < LATENCY; i++) begin
                pipe_reg[i] <= pipe_reg[i-1];
                vld_reg[i] <= vld_reg[i-1];
            end
        end else begin
            vld_reg <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pins
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sample_code_bus_out <= ASOP_CODE_ZERO;
            sample_code_bus_oe_out <= '0;
            mode_out <= 1'b0;
        end else begin
            if (mode_reg == ASOP_ACTIVE) begin
                sample_code_bus_out <= pipe_reg[LATENCY-1];
            end
            sample_code_bus_oe_out <= {ASOP_CODE_W{~oe_n_sync_reg}};
            mode_out <= mode_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fill tracking for the checks: active edges since reset or the last stop
    localparam int RUN_W = $clog2(LATENCY + 1);
    localparam int OUT_DELAY = LATENCY + 1;
    logic [RUN_W-1:0] run_cnt_reg;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            run_cnt_reg <= '0;
        end else if (mode_reg != ASOP_ACTIVE) begin
            run_cnt_reg <= '0;
        end else if (run_cnt_reg != RUN_W'(LATENCY)) begin
            run_cnt_reg <= run_cnt_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_active_run;
        !power_down_sync_reg [*2];
    endsequence

    // Power-down pin walks through both flops, then the mode, then the mode pin
    sequence s_sleep_path;
        power_down_meta_reg
        ##1 power_down_sync_reg
        ##1 (mode_reg == ASOP_POWER_DOWN)
        ##1 (mode_out == 1'b1);
    endsequence

    sequence s_wake_path;
        !power_down_meta_reg
        ##1 !power_down_sync_reg
        ##1 (mode_reg == ASOP_ACTIVE)
        ##1 (mode_out == 1'b0);
    endsequence

    // Output enable pin walks through both flops, then the drive enables
    sequence s_drive_path;
        !oe_n_meta_reg
        ##1 !oe_n_sync_reg
        ##1 (sample_code_bus_oe_out == 12'hfff);
    endsequence

    sequence s_float_path;
        oe_n_meta_reg
        ##1 oe_n_sync_reg
        ##1 (sample_code_bus_oe_out == 12'h000);
    endsequence

    a_pwr_mode_follow: assert property (@(posedge core_clk_in) disable iff (rst_in)
        power_down_sync_reg |=> (mode_reg == ASOP_POWER_DOWN) ##1 (mode_out == 1'b1))
        else $error("mode did not enter power-down");

    a_active_mode: assert property (@(posedge core_clk_in) disable iff (rst_in)
        s_active_run |=> mode_reg == ASOP_ACTIVE)
        else $error("mode not active");

    a_sleep_path: assert property (@(posedge core_clk_in) disable iff (rst_in)
        power_down_req_in |=> s_sleep_path)
        else $error("power-down pin not followed");

    a_wake_path: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !power_down_req_in |=> s_wake_path)
        else $error("active pin not followed");

    a_pipe_freeze: assert property (@(posedge core_clk_in) disable iff (rst_in)
        mode_reg == ASOP_POWER_DOWN |=> (vld_reg == '0) && $stable(sample_code_bus_out)
            && $stable(pipe_reg[LATENCY-1]))
        else $error("pipeline moved in power-down");

    a_oe_drive: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !oe_n_sync_reg |=> sample_code_bus_oe_out == 12'hfff)
        else $error("pins not driven");

    a_oe_float: assert property (@(posedge core_clk_in) disable iff (rst_in)
        oe_n_sync_reg |=> sample_code_bus_oe_out == 12'h000)
        else $error("pins not floated");

    a_drive_path: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !output_enable_n_in |=> s_drive_path)
        else $error("enable pin not followed");

    a_float_path: assert property (@(posedge core_clk_in) disable iff (rst_in)
        output_enable_n_in |=> s_float_path)
        else $error("release pin not followed");

    a_oe_uniform: assert property (@(posedge core_clk_in) disable iff (rst_in)
        sample_code_bus_oe_out == 12'h000 || sample_code_bus_oe_out == 12'hfff)
        else $error("pins not switched together");

    a_code_offset: assert property (@(posedge core_clk_in) disable iff (rst_in)
        code_next == (12'(quant_in) + ASOP_CODE_MID))
        else $error("offset binary code wrong");

    a_code_ends: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (quant_in == 12'sh800 |-> code_next == ASOP_CODE_ZERO) and
        (quant_in == 12'sh7ff |-> code_next == ASOP_CODE_FULL))
        else $error("code end points wrong");

    a_code_mid: assert property (@(posedge core_clk_in) disable iff (rst_in)
        quant_in == 12'sh000 |-> code_next == ASOP_CODE_MID)
        else $error("mid-scale code wrong");

    a_pipe_enter: assert property (@(posedge core_clk_in) disable iff (rst_in)
        mode_reg == ASOP_ACTIVE |=> pipe_reg[0] == $past(code_next))
        else $error("sample not taken");

    a_latency_out: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (mode_reg == ASOP_ACTIVE && vld_reg[LATENCY-1])
        |=> sample_code_bus_out == $past(pipe_reg[LATENCY-1]))
        else $error("word not presented");

    a_fill_track: assert property (@(posedge core_clk_in) disable iff (rst_in)
        vld_reg[LATENCY-1] == (run_cnt_reg == RUN_W'(LATENCY)))
        else $error("pipeline fill wrong");

    // End to end: a word sampled at one edge leaves a fixed number of edges later
    a_sample_span: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (mode_reg == ASOP_ACTIVE && run_cnt_reg == RUN_W'(LATENCY))
        |=> sample_code_bus_out == $past(code_next, OUT_DELAY))
        else $error("word latency wrong");
endmodule

/* sim/asop_capture.sv */
// Capture-side model: resolves the data pins seen by the capture logic
`timescale 1ns/1ps
module asop_capture
    import asop_pkg::*;
(
    input wire logic core_clk_in,
    input wire asop_pins_t pins_in,
    output logic [11:0] wire_level_out
);
    logic [11:0] last_reg;
    // Released pins float: show the inverse of the last driven level
    always_comb wire_level_out = (pins_in.oe & pins_in.data) | (~pins_in.oe & ~last_reg);
    always_ff @(posedge core_clk_in) begin
        last_reg <= (pins_in.oe & pins_in.data) | (~pins_in.oe & last_reg);
    end
endmodule

/* sim/tb_top.sv */
// Testbench: code stream, output enable and power-down of the port
`timescale 1ns/1ps
module tb_top
    import asop_pkg::*;
;
    logic core_clk = 0, rst = 1, oe_n = 0, power_down_req = 0, mode;
    logic signed [11:0] quant = 0;
    logic [11:0] bus, oe, level;
    asop_pins_t pins;
    int mismatches = 0, total_checks = 0, cycles = 0;
    assign pins = '{data: bus, oe: oe};
    always #20 core_clk = ~core_clk;
    asop_port #(.LATENCY(ASOP_LATENCY)) DUT (.core_clk_in(core_clk), .rst_in(rst),
        .quant_in(quant), .output_enable_n_in(oe_n), .power_down_req_in(power_down_req),
        .sample_code_bus_out(bus), .sample_code_bus_oe_out(oe), .mode_out(mode));
    asop_capture cap (.core_clk_in(core_clk), .pins_in(pins), .wire_level_out(level));
    task automatic check(string name, logic [11:0] exp, logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_stream();
        logic [11:0] v [8] = '{12'h800, 12'h7ff, 12'h000, 12'h001, 12'h555, 12'haaa,
            12'hfff, 12'h123};
        for (int j = 0; j < 8 + ASOP_LATENCY + 1; j++) begin
            @(negedge core_clk);
            if (j > ASOP_LATENCY) check("code", v[j-ASOP_LATENCY-1] ^ 12'h800, level);
            if (j < 8) quant = v[j];
        end
        $display("stream done");
    endtask
    task automatic test_enable();
        @(negedge core_clk) oe_n = 1;
        repeat (3) @(negedge core_clk);
        check("oe off", 12'h000, oe);
        check("float", 12'h6dc, level);
        oe_n = 0;
        repeat (3) @(negedge core_clk);
        check("oe on", 12'hfff, oe);
        check("drive", 12'h923, level);
        $display("enable done");
    endtask
    task automatic test_power();
        @(negedge core_clk) quant = 12'h321;
        repeat (ASOP_LATENCY + 2) @(negedge core_clk);
        power_down_req = 1;
        repeat (4) @(negedge core_clk);
        check("mode", 12'h001, {11'h0, mode});
        quant = 12'h000;
        repeat (10) @(negedge core_clk);
        check("frozen", 12'hb21, bus);
        power_down_req = 0;
        repeat (ASOP_LATENCY + 6) @(negedge core_clk);
        check("resumed", 12'h800, bus);
        check("mode", 12'h000, {11'h0, mode});
        $display("power done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 2000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(negedge core_clk);
        rst = 0;
        test_stream();
        test_enable();
        test_power();
        conclude();
    end
endmodule
